// ---- rtl/rtci_pkg.sv ----
/*
  Package for the radio time command interface: command codes, serial timing,
  reset-cycle length and response field positions.
  Assumes a 50 MHz system clock.
*/
package rtci_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BAUD_RATE = 2400;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int unsigned RESET_CYCLE_S = 2;
  localparam int unsigned RESET_CYCLES = RESET_CYCLE_S * CLK_HZ;
  localparam int unsigned SECOND_CYCLES = CLK_HZ;

  // ---------------------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_TIME = 8'h01;
  localparam logic [7:0] CMD_DIAG = 8'h02;
  localparam logic [7:0] CMD_FORCE_UPDATE = 8'h03;
  localparam logic [7:0] CMD_READ_UT1 = 8'h04;
  localparam logic [7:0] CMD_READ_FW = 8'hFF;

  // ---------------------------------------------------------------------------
  // response layout
  // ---------------------------------------------------------------------------
  localparam int unsigned TIME_MSG_BYTES = 8;
  localparam logic [7:0] UNVERIFIED_STATUS = 8'hE1;
  localparam logic [7:0] UNVERIFIED_DAY = 8'h01;
  localparam logic [1:0] QUALITY_VERIFIED = 2'h3;
  localparam logic [1:0] QUALITY_MAX = 2'h3;
  localparam logic [1:0] FLAG_MATCHES_NEEDED = 2'h3;
  localparam logic [7:0] FW_REVISION_DEFAULT = 8'h10; // arbitrary value

  typedef enum logic [2:0] {
    RTCI_TX_IDLE  = 3'b001,
    RTCI_TX_START = 3'b010,
    RTCI_TX_BITS  = 3'b100
  } rtci_tx_state_t;

endpackage

// ---- rtl/rtci_cmd_interface.sv ----
/*
  Command interpreter of a radio time decoder: 2400 8N1 serial receive and
  transmit, command decode, response sequencing and reception bookkeeping.
  Assumes the time-keeping and demodulator logic beside it supplies BCD time,
  flag readings and per-second symbol classes as synchronous inputs.
*/
`timescale 1ns/10ps

// Functional notes
// - commands are single bytes: 01 time, 02 diag, 03 update, 04 UT1, FF firmware
// - unknown command bytes are dropped with no reply and no state change
// - read time returns eight bytes: status, year, flags, day, hour, min, sec, subsec
// - time fields are captured when the command byte is received
// - status bits 7:5 give tens of hours since last good update
// - status bit 4 is high once flags are validated
// - status bits 3:2 give correlating frame count, saturating at three
// - status bits 1:0 give reception state: 00 idle, 01 receive, 11 noisy
// - year, day, minute, second and subsecond bytes are packed BCD
// - flag bit 7 leap second pending, bit 6 its sign
// - flag bits 5:4 carry daylight saving state and its transitions
// - flag bit 3 century, bit 2 leap year, bits 1:0 day hundreds
// - hour byte: tens digit in bits 5:4, units in bits 3:0
// - diagnostic mode sends one symbol byte per second until another valid command
// - forced update starts reception; stops at quality three with flags correlated
// - UT1 read returns sign bits, leap pending bit and tenths magnitude
// - firmware read returns major nibble high, revision nibble low
// - commands during the two second power-up reset cycle are ignored
// - until verified, read time answers E1 00 00 01 00 00 00 00
// - quality one after first valid frame; time verified at quality three
// - flags verified after three consecutive identical readings
// - reception restarts every UTC hour; flags re-verified daily at hour zero
// - serial link is 2400 baud, eight data bits, one stop bit, no parity
module rtci_cmd_interface import rtci_pkg::*; #(
  parameter int unsigned RESET_CYCLES_P = RESET_CYCLES,
  parameter int unsigned SECOND_CYCLES_P = SECOND_CYCLES,
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES,
  parameter logic [7:0] FW_REVISION = FW_REVISION_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // host serial link
  input wire logic rxd,
  output logic txd,
  // internal clock, BCD
  input wire logic [7:0] year_bcd_byte,
  input wire logic [9:0] day_bcd,
  input wire logic [5:0] hour_bcd_byte,
  input wire logic [6:0] minute_bcd,
  input wire logic [6:0] second_bcd,
  input wire logic [7:0] subsecond_bcd_byte,
  input wire logic hour_tick,
  // decoder events
  input wire logic frame_valid,
  input wire logic frame_correlates,
  input wire logic [7:0] frame_flags,
  input wire logic noisy,
  input wire logic symbol_tick,
  input wire logic [1:0] symbol_class,
  input wire logic [7:0] ut1_byte,
  // status
  output logic reception_active,
  output logic in_reset_cycle,
  output logic diag_active
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rx_sync;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    rtci_tx_state_t tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;
    logic txd;
    logic [7:0][7:0] msg;
    logic [3:0] msg_left;
    logic [3:0] msg_idx;
    logic [31:0] rst_cnt;
    logic in_rst;
    logic [31:0] sec_cnt;
    logic [2:0] hrs_since;
    logic [3:0] hr_units;
    logic time_ok;
    logic [1:0] quality;
    logic flags_ok;
    logic [1:0] flag_match;
    logic [7:0] last_flags;
    logic rcv;
    logic diag;
    logic [1:0] last_sym;
  } rtci_state_t;

  rtci_state_t s_q, s_d;

  logic [7:0] rx_byte;
  logic rx_done;
  logic [7:0] status_byte;

  assign txd = s_q.txd;
  assign reception_active = s_q.rcv;
  assign in_reset_cycle = s_q.in_rst;
  assign diag_active = s_q.diag;

  always_comb begin
    s_d = s_q;
    rx_done = 1'b0;
    rx_byte = s_q.rx_shift;
    status_byte = {s_q.hrs_since, s_q.flags_ok, s_q.quality, s_q.rcv & noisy, s_q.rcv};

    // -------------------------------------------------------------------------
    // power-up reset cycle
    // -------------------------------------------------------------------------
    if (s_q.in_rst) begin
      if (s_q.rst_cnt >= RESET_CYCLES_P - 1) begin
        s_d.in_rst = 1'b0;
        s_d.rcv = 1'b1; // reception starts on its own
      end else begin
        s_d.rst_cnt = s_q.rst_cnt + 32'h1;
      end
    end

    // -------------------------------------------------------------------------
    // serial receiver, 8N1, sampled mid-bit
    // -------------------------------------------------------------------------
    s_d.rx_sync = {s_q.rx_sync[0], rxd};
    if (!s_q.rx_busy) begin
      if (!s_q.rx_sync[1]) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_cnt = 16'(BIT_CYCLES_P / 2);
        s_d.rx_bit = 4'h0;
      end
    end else if (s_q.rx_cnt != 16'h0) begin
      s_d.rx_cnt = s_q.rx_cnt - 16'h1;
    end else begin
      s_d.rx_cnt = 16'(BIT_CYCLES_P - 1);
      s_d.rx_bit = s_q.rx_bit + 4'h1;
      if (s_q.rx_bit == 4'h0) begin
        if (s_q.rx_sync[1]) begin
          s_d.rx_busy = 1'b0; // false start
        end
      end else if (s_q.rx_bit <= 4'h8) begin
        s_d.rx_shift = {s_q.rx_sync[1], s_q.rx_shift[7:1]};
      end else begin
        s_d.rx_busy = 1'b0;
        rx_done = s_q.rx_sync[1]; // framing error drops byte
      end
    end

    // -------------------------------------------------------------------------
    // reception bookkeeping
    // -------------------------------------------------------------------------
    if (s_q.rcv && frame_valid) begin
      if (s_q.quality == 2'h0 || frame_correlates) begin
        if (s_q.quality != QUALITY_MAX) begin
          s_d.quality = s_q.quality + 2'h1;
        end
      end
      if (s_q.flag_match != 2'h0 && frame_flags == s_q.last_flags) begin
        if (s_q.flag_match != FLAG_MATCHES_NEEDED) begin
          s_d.flag_match = s_q.flag_match + 2'h1;
        end
      end else begin
        s_d.flag_match = 2'h1;
      end
      s_d.last_flags = frame_flags;
      if (s_d.flag_match == FLAG_MATCHES_NEEDED) begin
        s_d.flags_ok = 1'b1;
      end
      if (s_d.quality == QUALITY_VERIFIED) begin
        s_d.time_ok = 1'b1;
        s_d.hrs_since = 3'h0;
        s_d.hr_units = 4'h0;
      end
      // stop needs the flag match count at three, not the sticky valid bit; the count is cleared only by force update and at hour zero
      if (s_d.quality == QUALITY_VERIFIED && s_d.flag_match == FLAG_MATCHES_NEEDED) begin
        s_d.rcv = 1'b0;
      end
    end
    if (hour_tick && !s_q.in_rst) begin
      s_d.rcv = 1'b1;
      s_d.quality = 2'h0;
      if (hour_bcd_byte == 6'h00) begin
        s_d.flag_match = 2'h0; // daily flag re-verify
      end
      if (s_q.hr_units == 4'h9) begin
        s_d.hr_units = 4'h0;
        if (s_q.hrs_since != 3'h7) begin
          s_d.hrs_since = s_q.hrs_since + 3'h1;
        end
      end else begin
        s_d.hr_units = s_q.hr_units + 4'h1;
      end
    end

    // -------------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------------
    if (rx_done && !s_q.in_rst && s_q.msg_left == 4'h0) begin
      case (rx_byte)
        CMD_READ_TIME: begin
          s_d.diag = 1'b0;
          s_d.msg_left = 4'(TIME_MSG_BYTES);
          s_d.msg_idx = 4'h0;
          if (s_q.time_ok) begin
            // captured now, not at send time
            s_d.msg[0] = status_byte;
            s_d.msg[1] = year_bcd_byte;
            s_d.msg[2] = {s_q.last_flags[7:2], day_bcd[9:8]};
            s_d.msg[3] = day_bcd[7:0];
            s_d.msg[4] = {2'h0, hour_bcd_byte};
            s_d.msg[5] = {1'b0, minute_bcd};
            s_d.msg[6] = {1'b0, second_bcd};
            s_d.msg[7] = subsecond_bcd_byte;
          end else begin
            s_d.msg = '0;
            s_d.msg[0] = UNVERIFIED_STATUS;
            s_d.msg[3] = UNVERIFIED_DAY;
          end
        end
        CMD_DIAG: begin
          s_d.diag = 1'b1;
          s_d.sec_cnt = 32'h0;
        end
        CMD_FORCE_UPDATE: begin
          s_d.diag = 1'b0;
          s_d.rcv = 1'b1;
          s_d.quality = 2'h0;
          s_d.flag_match = 2'h0;
        end
        CMD_READ_UT1: begin
          s_d.diag = 1'b0;
          s_d.msg[0] = {ut1_byte[7:5], 1'b0, ut1_byte[3:0]};
          s_d.msg_left = 4'h1;
          s_d.msg_idx = 4'h0;
        end
        CMD_READ_FW: begin
          s_d.diag = 1'b0;
          s_d.msg[0] = FW_REVISION;
          s_d.msg_left = 4'h1;
          s_d.msg_idx = 4'h0;
        end
        default: begin
        end
      endcase
    end

    // -------------------------------------------------------------------------
    // diagnostic byte once a second
    // -------------------------------------------------------------------------
    if (symbol_tick) begin
      s_d.last_sym = symbol_class;
    end
    if (s_q.diag) begin
      if (s_q.sec_cnt >= SECOND_CYCLES_P - 1) begin
        s_d.sec_cnt = 32'h0;
        if (s_d.msg_left == 4'h0 && s_d.diag) begin
          s_d.msg[0] = {6'h00, s_q.last_sym};
          s_d.msg_left = 4'h1;
          s_d.msg_idx = 4'h0;
        end
      end else begin
        s_d.sec_cnt = s_q.sec_cnt + 32'h1;
      end
    end

    // -------------------------------------------------------------------------
    // serial transmitter
    // -------------------------------------------------------------------------
    case (s_q.tx_st)
      RTCI_TX_IDLE: begin
        s_d.txd = 1'b1;
        if (s_q.msg_left != 4'h0) begin
          s_d.tx_shift = {1'b1, s_q.msg[s_q.msg_idx[2:0]], 1'b0};
          s_d.msg_idx = s_q.msg_idx + 4'h1;
          s_d.msg_left = s_q.msg_left - 4'h1;
          s_d.tx_st = RTCI_TX_START;
        end
      end
      RTCI_TX_START: begin
        s_d.tx_bit = 4'h0;
        s_d.tx_cnt = 16'(BIT_CYCLES_P - 1);
        s_d.txd = s_q.tx_shift[0];
        s_d.tx_shift = {1'b1, s_q.tx_shift[9:1]};
        s_d.tx_st = RTCI_TX_BITS;
      end
      RTCI_TX_BITS: begin
        if (s_q.tx_cnt != 16'h0) begin
          s_d.tx_cnt = s_q.tx_cnt - 16'h1;
        end else if (s_q.tx_bit == 4'h9) begin
          s_d.tx_st = RTCI_TX_IDLE;
        end else begin
          s_d.tx_cnt = 16'(BIT_CYCLES_P - 1);
          s_d.tx_bit = s_q.tx_bit + 4'h1;
          s_d.txd = s_q.tx_shift[0];
          s_d.tx_shift = {1'b1, s_q.tx_shift[9:1]};
        end
      end
      default: begin
        s_d.tx_st = RTCI_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.rx_sync <= 2'h3;
      s_q.txd <= 1'b1;
      s_q.tx_st <= RTCI_TX_IDLE;
      s_q.in_rst <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ---- verification/rtci_host_model.sv ----
/*
  Host model: sends single command bytes and collects reply bytes.
  Assumes 8N1 framing at BIT_CYCLES_P clocks per bit.
*/
`timescale 1ns/10ps
module rtci_host_model #(
  parameter int unsigned BIT_CYCLES_P = 16
) (
  // clock
  input wire logic clk_sys,
  // serial link
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  initial rxd = 1'b1;

  // one byte, no terminator, lsb first, one stop bit, no parity
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys);
    rxd = 1'b0;
    repeat (BIT_CYCLES_P) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      repeat (BIT_CYCLES_P) @(negedge clk_sys);
    end
    rxd = 1'b1;
    repeat (BIT_CYCLES_P) @(negedge clk_sys);
  endtask

  // mid-cell sampling; a frame with a low stop bit is not kept
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT_CYCLES_P / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES_P) @(posedge clk_sys);
        sh = i < 8 ? {txd, sh[7:1]} : sh;
      end
      if (txd) begin
        rx_q.push_back(sh);
      end
    end
  end
endmodule

// ---- verification/rtci_cmd_interface_assertions.sv ----
/*
  Checker for the command interface: reply bit timing, reset cycle, reception.
  Assumes binding to the top module with its parameter values.
*/
`timescale 1ns/10ps
module rtci_checker import rtci_pkg::*; #(
  parameter int unsigned RESET_CYCLES_P = RESET_CYCLES,
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // watched signals
  input wire logic txd,
  input wire logic hour_tick,
  input wire logic frame_valid,
  input wire logic reception_active,
  input wire logic in_reset_cycle,
  input wire logic diag_active
);
  int rc_q;
  int lc_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rc_q <= 0;
      lc_q <= 0;
    end else begin
      rc_q <= in_reset_cycle ? rc_q + 1 : 0;
      lc_q <= txd ? 0 : lc_q + 1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence cycle_end_s;
    $fell(in_reset_cycle);
  endsequence
  sequence line_up_s;
    $rose(txd);
  endsequence

  reset_len_a: assert property (cycle_end_s |-> rc_q >= RESET_CYCLES_P - 1 && rc_q <= RESET_CYCLES_P + 1)
    else $error("reset cycle length wrong");
  rcv_start_a: assert property (cycle_end_s |-> reception_active)
    else $error("reception not started after reset cycle");
  quiet_reset_a: assert property (in_reset_cycle |-> txd)
    else $error("txd active during reset cycle");
  diag_gate_a: assert property (in_reset_cycle |-> !diag_active)
    else $error("diagnostic mode during reset cycle");
  bit_len_a: assert property (line_up_s |-> lc_q % BIT_CYCLES_P == 0)
    else $error("txd low run not whole bits");
  frame_max_a: assert property (line_up_s |-> lc_q <= 9 * BIT_CYCLES_P)
    else $error("txd low longer than a frame");
  hour_restart_a: assert property (hour_tick && !in_reset_cycle |-> ##[1:2] reception_active)
    else $error("hourly reception not started");
  rcv_stop_a: assert property ($fell(reception_active) |->
    $past(frame_valid) || $past(frame_valid, 2) || $past(frame_valid, 3))
    else $error("reception stopped without a frame");
endmodule

bind rtci_cmd_interface rtci_checker #(.RESET_CYCLES_P(RESET_CYCLES_P), .BIT_CYCLES_P(BIT_CYCLES_P)) chk (
  .clk_sys(clk_sys), .reset(reset), .txd(txd), .hour_tick(hour_tick), .frame_valid(frame_valid),
  .reception_active(reception_active), .in_reset_cycle(in_reset_cycle), .diag_active(diag_active));

// ---- verification/radio_time_cmd_interface_test.sv ----
/*
  Bench: command table, then verified time, hourly restart, diagnostic mode, mid-run reset.
  Assumes the host model and the checker are compiled first.
*/
`timescale 1ns/10ps
module radio_time_cmd_interface_test import rtci_pkg::*;;
  localparam int unsigned BITC = 16;
  localparam logic [7:0] FW = 8'h2C; // arbitrary value
  typedef struct {logic [7:0] cmd; int n; logic [63:0] e;} rtci_row_t;
  logic clk_sys, reset, rxd, txd, hour_tick, frame_valid, frame_correlates, noisy, symbol_tick;
  logic [7:0] year, flags, sub, ut1;
  logic [9:0] day;
  logic [5:0] hour;
  logic [6:0] mins, secs;
  logic [1:0] sym;
  logic rcv, rst_cyc, diag;
  int miscompares = 0;
  int compares = 0;
  rtci_row_t rows[6] = '{'{8'h01, 8, 64'hE100000100000000}, '{8'h04, 1, 64'hA300000000000000},
    '{8'hFF, 1, 64'h2C00000000000000}, '{8'h03, 0, 64'h0}, '{8'h05, 0, 64'h0}, '{8'h00, 0, 64'h0}};

  rtci_cmd_interface #(.RESET_CYCLES_P(200), .SECOND_CYCLES_P(500), .BIT_CYCLES_P(BITC), .FW_REVISION(FW)) dut (
    .clk_sys(clk_sys), .reset(reset), .rxd(rxd), .txd(txd), .year_bcd_byte(year), .day_bcd(day),
    .hour_bcd_byte(hour), .minute_bcd(mins), .second_bcd(secs), .subsecond_bcd_byte(sub),
    .hour_tick(hour_tick), .frame_valid(frame_valid), .frame_correlates(frame_correlates),
    .frame_flags(flags), .noisy(noisy), .symbol_tick(symbol_tick), .symbol_class(sym), .ut1_byte(ut1),
    .reception_active(rcv), .in_reset_cycle(rst_cyc), .diag_active(diag));
  rtci_host_model #(.BIT_CYCLES_P(BITC)) h (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t bit %b expected %b", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic expect_msg(input int n, input logic [63:0] e);
    chk_byte(8'(h.rx_q.size()), 8'(n));
    for (int i = 0; i < n; i++) chk_byte(h.rx_q[i], e[63 - 8 * i -: 8]);
    h.rx_q.delete();
  endtask
  task automatic cmd_msg(input logic [7:0] c, input int n, input logic [63:0] e);
    h.send(c);
    ticks(1400);
    expect_msg(n, e);
  endtask
  task automatic frame;
    frame_valid = 1'b1;
    ticks(1);
    frame_valid = 1'b0;
    ticks(3);
  endtask
  // reset, optionally a command inside the reset cycle, then wait for the cycle to end
  task automatic restart(input bit early);
    ticks(1);
    reset = 1'b1;
    ticks(4);
    reset = 1'b0;
    if (early) h.send(CMD_READ_TIME);
    for (int i = 0; i < 400 && rst_cyc; i++) ticks(1);
    chk_bit(rst_cyc, 1'b0);
    chk_bit(rcv, 1'b1);
  endtask

  initial begin
    reset = 1'b1;
    {hour_tick, frame_valid, frame_correlates, noisy, symbol_tick} = '0;
    year = 8'h99;
    flags = 8'hD8;
    sub = 8'h97;
    ut1 = 8'hB3;
    day = 10'h245;
    hour = 6'h23;
    mins = 7'h59;
    secs = 7'h58;
    sym = 2'h0;
    restart(1'b0);
    foreach (rows[i]) cmd_msg(rows[i].cmd, rows[i].n, rows[i].e);
    noisy = 1'b1;
    frame_correlates = 1'b1;
    repeat (3) frame();
    chk_bit(rcv, 1'b0);
    h.send(CMD_READ_TIME);
    mins = 7'h00;
    ticks(1400);
    expect_msg(8, 64'h1C99DA4523595897);
    hour_tick = 1'b1;
    ticks(1);
    hour_tick = 1'b0;
    ticks(2);
    chk_bit(rcv, 1'b1);
    cmd_msg(CMD_READ_TIME, 8, 64'h1399DA4523005897);
    h.send(CMD_DIAG);
    // each class in turn; invalid bytes leave the mode running
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 1200 && h.rx_q.size() == 0; i++) ticks(1);
      chk_byte(8'(h.rx_q.size()), 8'h01);
      chk_byte(h.rx_q[0], 8'(k));
      chk_bit(diag, 1'b1);
      h.rx_q.delete();
      sym = 2'(k + 1);
      symbol_tick = 1'b1;
      ticks(1);
      symbol_tick = 1'b0;
      h.send(k < 3 ? 8'h05 : CMD_READ_UT1);
    end
    ticks(1400);
    chk_bit(diag, 1'b0);
    expect_msg(1, 64'hA300000000000000);
    restart(1'b1);
    cmd_msg(CMD_READ_TIME, 8, 64'hE100000100000000);
    report_and_stop();
  end

  // nearly three times the expected run length
  initial begin
    #1ms;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
